// ==== design/sat_map.svh ====
`ifndef SAT_MAP_SVH
`define SAT_MAP_SVH

// ==========================================
// address layout
`define SAT_ADDR_W 24
`define SAT_OFS_LSB 0
`define SAT_OFS_W 12
`define SAT_BLK_LSB 12
`define SAT_BLK_W 7
`define SAT_SE_LSB 19
`define SAT_SE_W 4
`define SAT_CHK_BIT 23
`define SAT_CHK_OK 1'b0

// ==========================================
// sizes
`define SAT_PSA_BYTES 4096
`define SAT_SE_BYTES 524288
`define SAT_BLKS_PER_SE 128

// ==========================================
// map and selection
`define SAT_NUM_POS 16
`define SAT_ID_W 4
`define SAT_NUM_CE 3
`define SAT_NUM_IO_COMPUTE_ELEMENT 3
`define SAT_SEL_W 6
`define SAT_IO_COMPUTE_ELEMENT_SEL_LSB 3

// ==========================================
// timing
`define SAT_APPLY_CYC 2'h2

`endif

// ==== design/sat_pkg.sv ====
`include "sat_map.svh"

package sat_pkg;

	// ==========================================
	// sequencing states
	typedef enum logic [1:0] {
		SAT_ST_RUN,
		SAT_ST_WAIT,
		SAT_ST_APPLY_RUN,
		SAT_ST_APPLY_WAIT
	} sat_state_e;

	// ==========================================
	// carriers
	typedef struct packed {
		logic [`SAT_NUM_POS*`SAT_ID_W-1:0] assign_mask;
		logic [`SAT_SEL_W-1:0] select_mask;
	} sat_cmd_s;

	typedef struct packed {
		logic [`SAT_ADDR_W-1:0] addr;
		logic is_ifetch;
	} sat_ref_s;

	typedef struct packed {
		logic [`SAT_SE_W-1:0] se;
		logic [`SAT_BLK_W-1:0] blk;
	} sat_psa_s;

	typedef struct packed {
		logic [`SAT_ID_W-1:0] phys_se;
		logic [`SAT_BLK_W-1:0] blk;
		logic [`SAT_OFS_W-1:0] offset;
		logic in_ctrl_store;
		logic is_ifetch;
	} sat_xlat_s;

endpackage

// ==== design/sat_map_table.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sat_map.svh"

module sat_map_table #(
	parameter int NUM_POS = `SAT_NUM_POS,
	parameter int ID_W = `SAT_ID_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// load
	input wire logic load,
	input wire logic [NUM_POS*ID_W-1:0] load_mask,
	// lookup
	input wire logic [$clog2(NUM_POS)-1:0] rd_pos,
	output logic [ID_W-1:0] rd_id
);

	logic [ID_W-1:0] map_reg [NUM_POS];

	// ==========================================
	// map storage, identity after reset
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < NUM_POS; i++) begin
			if (sys_rst) begin
				map_reg[i] <= ID_W'(i);
			end else if (load) begin
				map_reg[i] <= load_mask[i*ID_W +: ID_W];
			end
		end
	end

	assign rd_id = map_reg[rd_pos];

endmodule
`default_nettype wire

// ==== design/sat_xlate.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sat_map.svh"

module sat_xlate #(
	parameter bit IS_IO_COMPUTE_ELEMENT = 1'b0,
	parameter int ELEM_NUM = 1,
	parameter logic [`SAT_SE_W-1:0] HW_PSA_SE = 4'h0,
	parameter logic [`SAT_BLK_W-1:0] HW_PSA_BLK = 7'h01
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// reassignment command broadcast
	input wire logic map_cmd_valid,
	input wire sat_pkg::sat_cmd_s map_cmd,
	// element status and sequencing
	input wire logic elem_wait_state,
	output logic elem_hold,
	output logic resume_ifetch,
	output logic resume_wait,
	output logic map_loaded,
	// preferential area control
	input wire logic single_proc,
	input wire logic psa_set_valid,
	input wire sat_pkg::sat_psa_s psa_set,
	input wire logic hw_psa_load,
	output sat_pkg::sat_psa_s psa_cur,
	// storage references
	input wire logic ref_valid,
	input wire sat_pkg::sat_ref_s ref_in,
	output logic xlat_valid,
	output sat_pkg::sat_xlat_s xlat,
	output logic addr_error,
	output logic ref_refused
);

	// ==========================================
	// selection decode
	localparam int SEL_IDX = IS_IO_COMPUTE_ELEMENT ? (`SAT_IO_COMPUTE_ELEMENT_SEL_LSB + ELEM_NUM - 1) : (ELEM_NUM - 1);

	sat_pkg::sat_state_e state_reg, state_next;
	logic [1:0] apply_cnt_reg;
	logic map_load;
	logic selected;

	// unselected elements ignore the broadcast and keep their map
	assign selected = map_cmd_valid && map_cmd.select_mask[SEL_IDX];

	// ==========================================
	// reassignment sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sat_pkg::SAT_ST_RUN: begin
				if (selected) begin
					state_next = sat_pkg::SAT_ST_APPLY_RUN;
				end else if (elem_wait_state) begin
					state_next = sat_pkg::SAT_ST_WAIT;
				end
			end
			sat_pkg::SAT_ST_WAIT: begin
				if (selected) begin
					state_next = sat_pkg::SAT_ST_APPLY_WAIT;
				end else if (!elem_wait_state) begin
					state_next = sat_pkg::SAT_ST_RUN;
				end
			end
			sat_pkg::SAT_ST_APPLY_RUN: begin
				if (apply_cnt_reg == 2'h0) begin
					state_next = sat_pkg::SAT_ST_RUN;
				end
			end
			sat_pkg::SAT_ST_APPLY_WAIT: begin
				if (apply_cnt_reg == 2'h0) begin
					state_next = sat_pkg::SAT_ST_WAIT;
				end
			end
			default: begin
				state_next = sat_pkg::SAT_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= sat_pkg::SAT_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// map is loaded on the first cycle of the apply phase
	assign map_load = (state_reg == sat_pkg::SAT_ST_RUN || state_reg == sat_pkg::SAT_ST_WAIT) && selected;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			apply_cnt_reg <= 2'h0;
		end else if (map_load) begin
			apply_cnt_reg <= `SAT_APPLY_CYC - 2'h1;
		end else if (apply_cnt_reg != 2'h0) begin
			apply_cnt_reg <= apply_cnt_reg - 2'h1;
		end
	end

	// ==========================================
	// held mask: captured so the table loads a stable copy
	sat_pkg::sat_cmd_s cmd_reg;
	logic load_pend_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmd_reg <= '0;
			load_pend_reg <= 1'b0;
		end else begin
			load_pend_reg <= map_load;
			if (map_load) begin
				cmd_reg <= map_cmd;
			end
		end
	end

	// ==========================================
	// logical to physical table
	logic [`SAT_SE_W-1:0] lookup_pos;
	logic [`SAT_ID_W-1:0] lookup_id;

	sat_map_table #(
		.NUM_POS(`SAT_NUM_POS),
		.ID_W(`SAT_ID_W)
	) u_map (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.load(load_pend_reg),
		.load_mask(cmd_reg.assign_mask),
		.rd_pos(lookup_pos),
		.rd_id(lookup_id)
	);

	// ==========================================
	// sequencing outputs
	logic applying;
	logic apply_end;

	assign applying = state_reg == sat_pkg::SAT_ST_APPLY_RUN || state_reg == sat_pkg::SAT_ST_APPLY_WAIT;
	assign apply_end = applying && apply_cnt_reg == 2'h0;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			elem_hold <= 1'b0;
		end else begin
			// hold covers load cycle so no fetch sees a half-written map
			elem_hold <= map_load || (applying && !apply_end);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			resume_ifetch <= 1'b0;
			resume_wait <= 1'b0;
			map_loaded <= 1'b0;
		end else begin
			resume_ifetch <= apply_end && state_reg == sat_pkg::SAT_ST_APPLY_RUN;
			resume_wait <= apply_end && state_reg == sat_pkg::SAT_ST_APPLY_WAIT;
			map_loaded <= load_pend_reg;
		end
	end

	// ==========================================
	// preferential storage area location
	sat_pkg::sat_psa_s psa_reg;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			psa_reg <= '0;
		end else if (hw_psa_load) begin
			psa_reg.se <= HW_PSA_SE;
			psa_reg.blk <= HW_PSA_BLK;
		end else if (psa_set_valid) begin
			psa_reg <= psa_set;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			psa_cur <= '0;
		end else begin
			psa_cur <= psa_reg;
		end
	end

	// ==========================================
	// address field split
	logic chk_bit;
	logic [`SAT_SE_W-1:0] log_se;
	logic [`SAT_BLK_W-1:0] log_blk;
	logic [`SAT_OFS_W-1:0] ofs;

	assign chk_bit = ref_in.addr[`SAT_CHK_BIT];
	assign log_se = ref_in.addr[`SAT_SE_LSB +: `SAT_SE_W];
	assign log_blk = ref_in.addr[`SAT_BLK_LSB +: `SAT_BLK_W];
	assign ofs = ref_in.addr[`SAT_OFS_LSB +: `SAT_OFS_W];

	// ==========================================
	// area relocation
	// on compute elements the low block and own area trade places; the io compute element
	// sends the low block to control storage, so each processor sees its own
	// control words at low addresses without disturbing the others
	logic low_blk;
	logic own_blk;
	logic relocate;
	logic [`SAT_SE_W-1:0] eff_se;
	logic [`SAT_BLK_W-1:0] eff_blk;
	logic to_ctrl;

	assign low_blk = log_se == '0 && log_blk == '0;
	assign own_blk = log_se == psa_reg.se && log_blk == psa_reg.blk;
	// single processor: control words stay at fixed low addresses
	assign relocate = !single_proc;

	always_comb begin
		eff_se = log_se;
		eff_blk = log_blk;
		to_ctrl = 1'b0;
		if (relocate && low_blk) begin
			if (IS_IO_COMPUTE_ELEMENT) begin
				to_ctrl = 1'b1;
			end else begin
				eff_se = psa_reg.se;
				eff_blk = psa_reg.blk;
			end
		end else if (relocate && own_blk && !IS_IO_COMPUTE_ELEMENT) begin
			eff_se = '0;
			eff_blk = '0;
		end
	end

	assign lookup_pos = eff_se;

	// ==========================================
	// reference result
	logic ref_ok;

	// a reference offered while the map is changing is refused, not queued
	assign ref_ok = ref_valid && !applying && !map_load;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			xlat_valid <= 1'b0;
			addr_error <= 1'b0;
			ref_refused <= 1'b0;
		end else begin
			xlat_valid <= ref_ok && chk_bit == `SAT_CHK_OK;
			addr_error <= ref_ok && chk_bit != `SAT_CHK_OK;
			ref_refused <= ref_valid && !ref_ok;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			xlat <= '0;
		end else if (ref_ok) begin
			xlat.phys_se <= to_ctrl ? '0 : lookup_id;
			xlat.blk <= eff_blk;
			xlat.offset <= ofs;
			xlat.in_ctrl_store <= to_ctrl;
			xlat.is_ifetch <= ref_in.is_ifetch;
		end
	end

endmodule
`default_nettype wire

// ==== verification/sat_xlate_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// reference and remap checks
module sat_xlate_sva #(parameter bit IS_IO_COMPUTE_ELEMENT = 1'h0, parameter int ELEM_NUM = 1) (
	// clock
	input wire logic core_clk,
	input wire logic sys_rst,
	// remap
	input wire logic map_cmd_valid,
	input wire sat_pkg::sat_cmd_s map_cmd,
	input wire logic elem_wait_state,
	input wire logic elem_hold,
	input wire logic resume_ifetch,
	input wire logic resume_wait,
	input wire logic map_loaded,
	// refs
	input wire logic single_proc,
	input wire logic ref_valid,
	input wire sat_pkg::sat_ref_s ref_in,
	input wire logic xlat_valid,
	input wire sat_pkg::sat_xlat_s xlat,
	input wire logic addr_error,
	input wire logic ref_refused
);
	localparam int SEL = IS_IO_COMPUTE_ELEMENT ? ELEM_NUM + 2 : ELEM_NUM - 1;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// a command in the resume cycle is not yet legal, so it is left out
	sequence s_cmd;
		map_cmd_valid && map_cmd.select_mask[SEL] && !elem_hold && !resume_ifetch && !resume_wait;
	endsequence
	sequence s_apply;
		elem_hold[*2] ##1 (!elem_hold && (resume_ifetch ^ resume_wait));
	endsequence
	property p_hold;
		s_cmd |=> s_apply;
	endproperty
	a_hold: assert property (p_hold) else $error("apply steps wrong");
	property p_loaded;
		s_cmd |-> ##2 map_loaded && elem_hold;
	endproperty
	a_loaded: assert property (p_loaded) else $error("map load late");
	property p_mode;
		s_cmd and $stable(elem_wait_state) |-> ##3 resume_wait == $past(elem_wait_state, 3);
	endproperty
	a_mode: assert property (p_mode) else $error("resume kind wrong");
	property p_refuse;
		ref_valid && elem_hold |=> ref_refused;
	endproperty
	a_refuse: assert property (p_refuse) else $error("ref not refused");
	property p_answer;
		ref_valid |=> $onehot({xlat_valid, addr_error, ref_refused});
	endproperty
	a_answer: assert property (p_answer) else $error("answer count wrong");
	property p_err;
		ref_valid && ref_in.addr[23] ##1 !ref_refused |-> addr_error && !xlat_valid;
	endproperty
	a_err: assert property (p_err) else $error("bit check missed");
	property p_ofs;
		ref_valid ##1 xlat_valid |-> xlat.offset == $past(ref_in.addr[11:0]);
	endproperty
	a_ofs: assert property (p_ofs) else $error("offset wrong");
	property p_blk;
		ref_valid && single_proc ##1 xlat_valid |-> xlat.blk == $past(ref_in.addr[18:12]);
	endproperty
	a_blk: assert property (p_blk) else $error("block wrong");
endmodule
bind sat_xlate sat_xlate_sva #(.IS_IO_COMPUTE_ELEMENT(IS_IO_COMPUTE_ELEMENT), .ELEM_NUM(ELEM_NUM)) u_sva (.core_clk, .sys_rst,
	.map_cmd_valid, .map_cmd, .elem_wait_state, .elem_hold, .resume_ifetch, .resume_wait, .map_loaded,
	.single_proc, .ref_valid, .ref_in, .xlat_valid, .xlat, .addr_error, .ref_refused);
`default_nettype wire

// ==== verification/sat_elem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// processor element beside the block
module sat_elem_model (
	// clock
	input wire logic core_clk,
	input wire logic sys_rst,
	// bench control
	input wire logic want_wait,
	input wire logic [23:0] fetch_addr,
	// block side
	input wire logic resume_ifetch,
	output logic elem_wait_state,
	output logic pm_ref_valid,
	output sat_pkg::sat_ref_s pm_ref
);
	// membership moves use a separate configuration path, not modelled here
	// the program parks the element before remapping when asked
	always_ff @(posedge core_clk) begin
		elem_wait_state <= !sys_rst && want_wait;
	end
	// idle ref bus toggles so a stale value is never mistaken for data
	always_ff @(posedge core_clk) begin
		pm_ref_valid <= !sys_rst && resume_ifetch;
		pm_ref <= resume_ifetch ? {fetch_addr, 1'h1} : ~pm_ref;
	end
endmodule
`default_nettype wire

// ==== verification/storage_address_translation_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module storage_address_translation_tb_top;
	// ==========
	// signals
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic map_cmd_valid = 1'h0, want_wait = 1'h0, single_proc = 1'h1, psa_set_valid = 1'h0, hw_psa_load = 1'h0;
	logic tb_rv = 1'h0, elem_hold, resume_ifetch, resume_wait, map_loaded, xlat_valid, addr_error, ref_refused;
	logic elem_wait_state, pm_rv, ref_valid, io_xv;
	sat_pkg::sat_cmd_s map_cmd = '0;
	sat_pkg::sat_psa_s psa_set = '0, psa_cur;
	sat_pkg::sat_ref_s tb_ref = '0, pm_ref, ref_in;
	sat_pkg::sat_xlat_s xlat, io_xlat;
	int num_errors = 0, samples_checked = 0;
	always #5 core_clk = ~core_clk;
	assign ref_valid = tb_rv | pm_rv;
	assign ref_in = pm_rv ? pm_ref : tb_ref;
	sat_xlate #(.IS_IO_COMPUTE_ELEMENT(1'h0), .ELEM_NUM(2), .HW_PSA_SE(4'h3), .HW_PSA_BLK(7'h05)) dut (.core_clk, .sys_rst,
		.map_cmd_valid, .map_cmd, .elem_wait_state, .elem_hold, .resume_ifetch, .resume_wait, .map_loaded,
		.single_proc, .psa_set_valid, .psa_set, .hw_psa_load, .psa_cur, .ref_valid, .ref_in, .xlat_valid,
		.xlat, .addr_error, .ref_refused);
	sat_elem_model pm (.core_clk, .sys_rst, .want_wait, .fetch_addr(24'h100000), .resume_ifetch,
		.elem_wait_state, .pm_ref_valid(pm_rv), .pm_ref);
	// io compute element copy: only this one can route an area into control storage
	sat_xlate #(.IS_IO_COMPUTE_ELEMENT(1'h1), .ELEM_NUM(1), .HW_PSA_SE(4'h3), .HW_PSA_BLK(7'h05)) dut_io (.core_clk, .sys_rst,
		.map_cmd_valid, .map_cmd, .elem_wait_state, .elem_hold(), .resume_ifetch(), .resume_wait(), .map_loaded(),
		.single_proc, .psa_set_valid, .psa_set, .hw_psa_load, .psa_cur(), .ref_valid, .ref_in, .xlat_valid(io_xv),
		.xlat(io_xlat), .addr_error(), .ref_refused());
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic do_ref(input logic [23:0] a, input logic [3:0] se, input logic [6:0] b, input logic err);
		@(posedge core_clk);
		tb_rv <= 1'h1;
		tb_ref <= {a, 1'h0};
		@(posedge core_clk);
		tb_rv <= 1'h0;
		#1;
		chk("addr_error", addr_error, err);
		chk("xlat_valid", xlat_valid, !err);
		if (!err) begin
			chk("phys_se", xlat.phys_se, se);
			chk("blk", xlat.blk, b);
			chk("offset", xlat.offset, a[11:0]);
		end
	endtask
	// a ref rides with the command so the refusal window is hit
	task automatic run_cmd(input logic [63:0] am, input logic [5:0] sm, input logic sel, input logic w);
		int h, rf, n;
		logic gi, gw, ml;
		logic [3:0] pse;
		h = 0;
		rf = 0;
		n = 0;
		{gi, gw, ml, pse} = '0;
		@(posedge core_clk);
		map_cmd_valid <= 1'h1;
		map_cmd <= {am, sm};
		tb_rv <= 1'h1;
		tb_ref <= {24'h000ABC, 1'h0};
		@(posedge core_clk);
		map_cmd_valid <= 1'h0;
		repeat (8) begin
			#1;
			h += elem_hold;
			rf += ref_refused;
			{gi, gw, ml} = {gi, gw, ml} | {resume_ifetch, resume_wait, map_loaded};
			if (xlat_valid && xlat.is_ifetch) pse = xlat.phys_se;
			@(posedge core_clk);
			n++;
			// refs stay offered across the whole three-cycle refusal window
			if (n == 2) tb_rv <= 1'h0;
		end
		chk("hold cycles", h, sel ? 32'h2 : 32'h0);
		chk("map_loaded", ml, sel);
		chk("ref_refused", rf, sel ? 32'h3 : 32'h0);
		chk("resume_ifetch", gi, sel && !w);
		chk("resume_wait", gw, sel && w);
		if (sel && !w) chk("fetch se", pse, 4'h8);
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		chk("idle outputs", {elem_hold, xlat_valid, addr_error, ref_refused, map_loaded}, 32'h0);
		do_ref(24'h292345, 4'h5, 7'h12, 1'h0);
	endtask
	task automatic t_decode();
		do_ref(24'h7FFFFF, 4'hF, 7'h7F, 1'h0);
		do_ref(24'h07F001, 4'h0, 7'h7F, 1'h0);
		do_ref(24'h000000, 4'h0, 7'h00, 1'h0);
		do_ref(24'h800123, 4'h0, 7'h00, 1'h1);
		do_ref(24'hFFFFFF, 4'h0, 7'h00, 1'h1);
	endtask
	task automatic t_remap();
		run_cmd(64'hFEDCBA9876543810, 6'h02, 1'h1, 1'h0);
		do_ref(24'h100000, 4'h8, 7'h00, 1'h0);
		run_cmd(64'h0, 6'h05, 1'h0, 1'h0);
		do_ref(24'h292345, 4'h5, 7'h12, 1'h0);
		want_wait <= 1'h1;
		repeat (3) @(posedge core_clk);
		run_cmd(64'hFEDCBA9876543210, 6'h02, 1'h1, 1'h1);
		want_wait <= 1'h0;
		do_ref(24'h100000, 4'h2, 7'h00, 1'h0);
	endtask
	task automatic t_area();
		@(posedge core_clk);
		single_proc <= 1'h0;
		psa_set_valid <= 1'h1;
		psa_set <= {4'h4, 7'h09};
		@(posedge core_clk);
		psa_set_valid <= 1'h0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("psa_cur", psa_cur, {4'h4, 7'h09});
		do_ref(24'h000010, 4'h4, 7'h09, 1'h0);
		chk("io_compute_element area", {io_xv, io_xlat.in_ctrl_store, io_xlat.phys_se}, 6'h30);
		chk("ce area", xlat.in_ctrl_store, 1'h0);
		do_ref(24'h209010, 4'h0, 7'h00, 1'h0);
		chk("io_compute_element own", {io_xlat.in_ctrl_store, io_xlat.phys_se, io_xlat.blk}, {1'h0, 4'h4, 7'h09});
		@(posedge core_clk);
		{hw_psa_load, psa_set_valid} <= 2'h3;
		@(posedge core_clk);
		{hw_psa_load, psa_set_valid} <= 2'h0;
		do_ref(24'h000020, 4'h3, 7'h05, 1'h0);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'h0;
		#1;
		t_reset();
		t_decode();
		t_remap();
		t_area();
		end_of_test();
	end
endmodule
`default_nettype wire
